/* File: sdas_pkg.sv */
// Package of constants and types for the sigma-delta autoscan result block.
`default_nettype none
package sdas_pkg;
  // Register byte addresses.
  localparam logic [19:0] SDAS_ADDR_RES_CHAN   = 20'hf0450;
  localparam logic [19:0] SDAS_ADDR_RES_LOW    = 20'hf0451;
  localparam logic [19:0] SDAS_ADDR_RES_MID    = 20'hf0452;
  localparam logic [19:0] SDAS_ADDR_RES_HIGH   = 20'hf0453;
  localparam logic [19:0] SDAS_ADDR_MEAN_CHAN  = 20'hf0454;
  localparam logic [19:0] SDAS_ADDR_MEAN_LOW   = 20'hf0455;
  localparam logic [19:0] SDAS_ADDR_MEAN_MID   = 20'hf0456;
  localparam logic [19:0] SDAS_ADDR_MEAN_HIGH  = 20'hf0457;
  localparam logic [19:0] SDAS_ADDR_CTRL       = 20'hf0459;
  localparam logic [19:0] SDAS_ADDR_CH_BASE    = 20'hf045a;
  localparam logic [19:0] SDAS_ADDR_CH_STRIDE  = 20'h00004;
  // Offsets inside one channel block of four registers.
  localparam logic [1:0]  SDAS_CH_OFS_PARAM    = 2'h0;
  localparam logic [1:0]  SDAS_CH_OFS_COUNT    = 2'h2;
  localparam logic [1:0]  SDAS_CH_OFS_AVG      = 2'h3;
  // Reset values.
  localparam logic [7:0]  SDAS_RST_PARAM       = 8'h40;
  localparam logic [7:0]  SDAS_RST_COUNT       = 8'h01;
  localparam logic [7:0]  SDAS_RST_ZERO        = 8'h00;
  // Field positions.
  localparam int          SDAS_CTRL_START      = 7;
  localparam int          SDAS_CTRL_SCAN       = 5;
  localparam int          SDAS_CHAN_CLIP       = 4;
  localparam int          SDAS_AVG_LINEAR      = 7;
  localparam int          SDAS_AVG_MODE_HI     = 3;
  localparam int          SDAS_AVG_MODE_LO     = 2;
  localparam int          SDAS_NUM_CH          = 4;
  localparam logic [7:0]  SDAS_CTRL_WMASK      = 8'hef;
  localparam logic [7:0]  SDAS_AVG_WMASK       = 8'h8f;
  // Sequencer states.
  typedef enum logic [1:0] {
    SDAS_IDLE = 2'b00,
    SDAS_LOAD = 2'b01,
    SDAS_CONV = 2'b10
  } sdas_state_t;
endpackage
`default_nettype wire

/* File: sdas_count.sv */
// Converts a channel count register into a number of conversions.
`default_nettype none
module sdas_count (
  input  wire logic [7:0]  count_i,   // Count field, n in bits 7:5, m in 4:0.
  input  wire logic        linear_i,  // High selects linear counting.
  output logic      [12:0] total_o    // Number of conversions on the channel.
);
  import sdas_pkg::*;
  logic [12:0] n_pow;  // Two to the power n.
  logic [12:0] m_ext;  // Field m widened.
  // Exponential form 32*(2^n-1)+m*2^n, or linear form 32*n+m.
  always_comb begin
    n_pow = 13'h0001 << count_i[7:5];
    m_ext = {8'h00, count_i[4:0]};
    if (linear_i) begin
      total_o = {5'h00, count_i};  // RULE_22
    end else begin
      total_o = 13'((n_pow - 13'h0001) << 5) + 13'(m_ext * n_pow);  // RULE_22
    end
  end
endmodule
`default_nettype wire

/* File: sdas_mean.sv */
// Running accumulator that averages 8 to 64 results.
`default_nettype none
module sdas_mean (
  input  wire logic        clk_i,     // System clock.
  input  wire logic        rst_n_i,   // Synchronous reset, active low.
  input  wire logic        clear_i,   // Restarts accumulation.
  input  wire logic        valid_i,   // One sample arrives.
  input  wire logic [23:0] sample_i,  // Signed sample.
  input  wire logic        clip_i,    // Sample was saturated.
  input  wire logic [1:0]  len_i,     // Length code: 8, 16, 32, 64.
  output logic             done_o,    // Mean complete this cycle.
  output logic      [23:0] mean_o,    // Mean value when done.
  output logic             clip_o     // Some sample in the mean was clipped.
);
  import sdas_pkg::*;
  logic signed [29:0] acc_q;    // Sum of samples.
  logic        [6:0]  cnt_q;    // Samples taken so far.
  logic               clip_q;   // Sticky clip within this window.
  logic signed [29:0] acc_d;    // Sum including the new sample.
  logic        [6:0]  target;   // Window length.
  // Combines the new sample with the running sum.
  always_comb begin
    acc_d  = acc_q + 30'(signed'(sample_i));
    target = 7'h08 << len_i;  // RULE_23
    done_o = valid_i && (cnt_q + 7'h01 == target);
    mean_o = 24'(acc_d >>> (7'd3 + 7'(len_i)));
    clip_o = clip_q | clip_i;  // RULE_06
  end
  // Accumulates and restarts after each complete window.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i || done_o) begin
      acc_q  <= '0;
      cnt_q  <= 7'h00;
      clip_q <= 1'b0;
    end else if (valid_i) begin
      acc_q  <= acc_d;
      cnt_q  <= cnt_q + 7'h01;
      clip_q <= clip_q | clip_i;
    end
  end
endmodule
`default_nettype wire

/* File: sdas_top.sv */
// Autoscan sequencer and result registers of the sigma-delta converter.
`default_nettype none
// Notes on behaviour
// RULE_01: Result clip bit follows result saturation.
// RULE_02: Low result byte, read-only, resets zero.
// RULE_03: Middle result byte, read-only, resets zero.
// RULE_04: High result byte, read-only, resets zero.
// RULE_05: Mean channel code in bits 7:5.
// RULE_06: Mean clip set if any sample clipped.
// RULE_07: Three mean bytes, consecutive, reset zero.
// RULE_08: Channel and low result read as word.
// RULE_09: Middle and high result read as word.
// RULE_10: Mean bytes likewise paired into two words.
// RULE_11: Start bit runs round-robin over channels.
// RULE_12: Skipped channels are passed over.
// RULE_13: Each channel converts its programmed count.
// RULE_14: Count zero means one-shot then stop.
// RULE_15: Channel parameters applied on channel switch.
// RULE_16: Interrupt per conversion without averaging.
// RULE_17: With averaging, interrupt per conversion or mean.
// RULE_18: Scan-end interrupt after each cycle.
// RULE_19: Single channel still gives scan-end interrupt.
// RULE_20: Scan mode zero continuous, one single; trigger forces single.
// RULE_21: Skip bit one disables channel.
// RULE_22: Count from m and n, exponential or linear.
// RULE_23: Average length 8, 16, 32 or 64.
// RULE_24: Single stops after cycle; continuous restarts.
// RULE_25: Channel, clip and bytes update together.
module sdas_top (
  input  wire logic        clk_i,         // System clock, 200 MHz.
  input  wire logic        rst_n_i,       // Synchronous reset, active low.
  input  wire logic [19:0] addr_i,        // Register byte address.
  input  wire logic        wr_i,          // Byte write strobe.
  input  wire logic [7:0]  wdata_i,       // Write data.
  input  wire logic        rd_i,          // Read strobe.
  input  wire logic        rd16_i,        // High for a 16-bit read at an even address.
  output logic      [15:0] rdata_o,       // Read data, registered.
  input  wire logic        hw_trig_i,     // Hardware trigger mode selected.
  input  wire logic        conv_done_i,   // Filter delivers a result.
  input  wire logic [23:0] conv_data_i,   // Result after clipping.
  input  wire logic        conv_clip_i,   // Result was saturated.
  output logic             conv_run_o,    // Converter runs on the current channel.
  output logic      [1:0]  conv_chan_o,   // Channel being converted.
  output logic      [7:0]  conv_param_o,  // Gain and oversampling of that channel.
  output logic             conversion_done_irq_o,  // One-cycle conversion interrupt.
  output logic             scan_end_irq_o          // One-cycle scan-end interrupt.
);
  import sdas_pkg::*;
  // Channels are visited in order.
  // A set skip bit passes one over.
  // Each turn runs the channel count.
  // Count zero converts once, then stops.
  // Continuous scans wrap to the start.
  // Single scans clear start at the end.
  // A hardware trigger forces single.
  // A result set lands in one edge.
  // Skip bits must stay fixed mid-scan.
  // Averaging shares one accumulator.

  // Software registers.
  logic [7:0]  ctrl_q;                       // Start, scan mode and skip bits.
  logic [7:0]  param_q [SDAS_NUM_CH];        // Per-channel gain and ratio.
  logic [7:0]  count_q [SDAS_NUM_CH];        // Per-channel count field.
  logic [7:0]  avg_q   [SDAS_NUM_CH];        // Per-channel averaging control.
  // Result registers.
  logic [7:0]  res_chan_q;                   // Result channel code and clip.
  logic [23:0] res_q;                        // Latest conversion result.
  logic [7:0]  mean_chan_q;                  // Mean channel code and clip.
  logic [23:0] mean_q;                       // Latest mean.
  // Sequencer state.
  sdas_state_t state_q;                      // Sequencer state.
  logic [1:0]  chan_q;                       // Current channel.
  logic [12:0] done_cnt_q;                   // Conversions done on this channel.
  logic        chan_seen_q;                  // A channel turn has ended since the scan started.

  // Decode of write targets.
  logic        ch_hit;                       // Address in the channel block.
  logic [19:0] ch_off;                       // Offset from channel base.
  logic [1:0]  ch_idx;                       // Channel addressed.
  logic [1:0]  ch_reg;                       // Register within channel.
  logic [12:0] chan_total;                   // Conversions for current channel.
  logic        mean_done;                    // Averager completes a mean.
  logic [23:0] mean_val;                     // New mean value.
  logic        mean_clip;                    // New mean clip flag.
  logic        avg_on;                       // Averaging enabled on channel.
  logic        last_conv;                    // This conversion ends the channel turn.
  logic        single_mode;                  // Stop after one cycle.
  logic [1:0]  next_ch;                      // Next enabled channel.
  logic        wrapped;                      // Next channel lies past the scan end.
  logic        any_en;                       // Some channel is enabled.

  // Four registers per channel block;
  // the low offset bits pick the register.
  always_comb begin
    ch_off = addr_i - SDAS_ADDR_CH_BASE;
    ch_hit = (addr_i >= SDAS_ADDR_CH_BASE) && (ch_off < 20'h00010);
    ch_idx = ch_off[3:2];
    ch_reg = ch_off[1:0];
  end

  // Count of conversions for the active channel.
  // It follows the channel at once.
  sdas_count u_count (
    .count_i  (count_q[chan_q]),
    .linear_i (avg_q[chan_q][SDAS_AVG_LINEAR]),
    .total_o  (chan_total)
  );

  // Averager shared across channels, restarted on every channel switch.
  // It is fed only when averaging is on,
  // so plain channels leave it idle.
  sdas_mean u_mean (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .clear_i  (state_q != SDAS_CONV),
    .valid_i  (conv_done_i && state_q == SDAS_CONV && avg_on),
    .sample_i (conv_data_i),
    .clip_i   (conv_clip_i),
    .len_i    (avg_q[chan_q][1:0]),
    .done_o   (mean_done),
    .mean_o   (mean_val),
    .clip_o   (mean_clip)
  );

  // Finds the next enabled channel after the current one, round-robin.
  // Farthest first, so the nearest wins.
  // A lower or equal index is a wrap.
  always_comb begin
    any_en      = ~&ctrl_q[3:0];  // RULE_21
    avg_on      = avg_q[chan_q][SDAS_AVG_MODE_HI];
    single_mode = ctrl_q[SDAS_CTRL_SCAN] | hw_trig_i;  // RULE_20
    last_conv   = (done_cnt_q + 13'h0001 >= chan_total);  // RULE_13
    next_ch     = chan_q;
    wrapped     = 1'b1;
    for (int k = 3; k >= 1; k--) begin
      if (!ctrl_q[2'(chan_q + 2'(k))]) begin  // RULE_12
        next_ch = 2'(chan_q + 2'(k));
        wrapped = (2'(chan_q + 2'(k)) <= chan_q);
      end
    end
  end

  // Control register writes; the sequencer clears the start bit when it stops.
  // A software write beats the clear,
  // so a restart at scan end is kept.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= SDAS_RST_ZERO;
    end else if (wr_i && addr_i == SDAS_ADDR_CTRL) begin
      ctrl_q <= wdata_i & SDAS_CTRL_WMASK;
    end else if (state_q == SDAS_CONV && conv_done_i && last_conv &&
                 ((count_q[chan_q] == 8'h00) || (single_mode && wrapped))) begin
      ctrl_q[SDAS_CTRL_START] <= 1'b0;  // RULE_14 RULE_24
    end
  end

  // Per-channel configuration registers, one generate entry per channel.
  // Reserved averaging bits are masked,
  // so they always read back as zero.
  for (genvar g = 0; g < SDAS_NUM_CH; g++) begin : g_ch
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        param_q[g] <= SDAS_RST_PARAM;
        count_q[g] <= SDAS_RST_COUNT;
        avg_q[g]   <= SDAS_RST_ZERO;
      end else if (wr_i && ch_hit && ch_idx == 2'(g)) begin
        if (ch_reg == SDAS_CH_OFS_PARAM) param_q[g] <= wdata_i;
        if (ch_reg == SDAS_CH_OFS_COUNT) count_q[g] <= wdata_i;
        if (ch_reg == SDAS_CH_OFS_AVG)   avg_q[g]   <= wdata_i & SDAS_AVG_WMASK;
      end
    end
  end

  // Autoscan sequencer.
  // IDLE starts at channel 0.
  // LOAD passes skipped channels over
  // and clears the count of the turn.
  // CONV counts results of the turn.
  // A stop or no enabled channel
  // returns the sequencer to IDLE.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !ctrl_q[SDAS_CTRL_START] || !any_en) begin
      state_q     <= SDAS_IDLE;
      chan_q      <= 2'h0;
      done_cnt_q  <= 13'h0000;
      chan_seen_q <= 1'b0;
    end else begin
      case (state_q)
        SDAS_IDLE: begin
          chan_q <= 2'h0;  // RULE_11
          state_q <= SDAS_LOAD;
        end
        SDAS_LOAD: begin
          if (ctrl_q[chan_q]) begin
            chan_q <= next_ch;  // RULE_11 RULE_12
          end else begin
            done_cnt_q <= 13'h0000;
            state_q    <= SDAS_CONV;  // RULE_15
          end
        end
        SDAS_CONV: begin
          if (conv_done_i) begin
            if (last_conv) begin
              done_cnt_q  <= 13'h0000;
              chan_q      <= next_ch;  // RULE_11
              chan_seen_q <= 1'b1;
              state_q     <= SDAS_LOAD;
            end else begin
              done_cnt_q <= done_cnt_q + 13'h0001;
            end
          end
        end
        default: state_q <= SDAS_IDLE;
      endcase
    end
  end

  // Captures the result set in one edge so reads stay coherent.
  // Pulses outside CONV are ignored,
  // so stray results corrupt nothing.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_chan_q <= SDAS_RST_ZERO;
      res_q      <= 24'h000000;
    end else if (conv_done_i && state_q == SDAS_CONV) begin
      res_chan_q <= {3'(chan_q) + 3'h1, conv_clip_i, 4'h0};  // RULE_01 RULE_25
      res_q      <= conv_data_i;  // RULE_02 RULE_03 RULE_04 RULE_25
    end
  end

  // Captures a completed mean with its channel and clip flag.
  // Code and clip refer to the window
  // that closes in this very cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mean_chan_q <= SDAS_RST_ZERO;
      mean_q      <= 24'h000000;
    end else if (mean_done) begin
      mean_chan_q <= {3'(chan_q) + 3'h1, mean_clip, 4'h0};  // RULE_05 RULE_06
      mean_q      <= mean_val;  // RULE_07
    end
  end

  // Interrupt pulses.
  // In per-mean mode only the result
  // that ends a window interrupts.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conversion_done_irq_o <= 1'b0;
      scan_end_irq_o        <= 1'b0;
    end else begin
      conversion_done_irq_o <= conv_done_i && state_q == SDAS_CONV &&
                               (!avg_on || !avg_q[chan_q][SDAS_AVG_MODE_LO] || mean_done);  // RULE_16 RULE_17
      scan_end_irq_o        <= conv_done_i && state_q == SDAS_CONV && last_conv && wrapped;  // RULE_18 RULE_19
    end
  end

  // Converter steering outputs.
  // Run drops after the last result
  // and returns two cycles after LOAD.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conv_run_o   <= 1'b0;
      conv_chan_o  <= 2'h0;
      conv_param_o <= SDAS_RST_PARAM;
    end else begin
      conv_run_o   <= (state_q == SDAS_CONV) && !(conv_done_i && last_conv);
      conv_chan_o  <= chan_q;
      conv_param_o <= param_q[chan_q];  // RULE_15
    end
  end

  // Read port: bytes, or 16-bit pairs at the even address.
  // Bytes sit in the low half; a word
  // adds the byte above in the high half.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        SDAS_ADDR_RES_CHAN:  rdata_o <= rd16_i ? {res_q[7:0], res_chan_q} : {8'h00, res_chan_q};  // RULE_08
        SDAS_ADDR_RES_LOW:   rdata_o <= {8'h00, res_q[7:0]};
        SDAS_ADDR_RES_MID:   rdata_o <= rd16_i ? res_q[23:8] : {8'h00, res_q[15:8]};  // RULE_09
        SDAS_ADDR_RES_HIGH:  rdata_o <= {8'h00, res_q[23:16]};
        SDAS_ADDR_MEAN_CHAN: rdata_o <= rd16_i ? {mean_q[7:0], mean_chan_q} : {8'h00, mean_chan_q};  // RULE_10
        SDAS_ADDR_MEAN_LOW:  rdata_o <= {8'h00, mean_q[7:0]};
        SDAS_ADDR_MEAN_MID:  rdata_o <= rd16_i ? mean_q[23:8] : {8'h00, mean_q[15:8]};  // RULE_10
        SDAS_ADDR_MEAN_HIGH: rdata_o <= {8'h00, mean_q[23:16]};
        SDAS_ADDR_CTRL:      rdata_o <= {8'h00, ctrl_q};
        default: begin
          if (ch_hit) begin
            case (ch_reg)
              SDAS_CH_OFS_PARAM: rdata_o <= {8'h00, param_q[ch_idx]};
              SDAS_CH_OFS_COUNT: rdata_o <= {8'h00, count_q[ch_idx]};
              SDAS_CH_OFS_AVG:   rdata_o <= {8'h00, avg_q[ch_idx]};
              default:           rdata_o <= 16'h0000;
            endcase
          end else begin
            rdata_o <= 16'h0000;
          end
        end
      endcase
    end
  end

  // Checks on result capture and sequencing.
  // All checks rest during reset.
  chk_result_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_25
    (conv_done_i && state_q == SDAS_CONV) |=> (res_q == $past(conv_data_i)))
    else $error("result not captured");
  chk_clip_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_01
    (conv_done_i && state_q == SDAS_CONV) |=> (res_chan_q[SDAS_CHAN_CLIP] == $past(conv_clip_i)))
    else $error("clip bit wrong");
  chk_chan_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_05
    mean_done |=> (mean_chan_q[7:5] == 3'($past(chan_q)) + 3'h1))
    else $error("mean channel code wrong");
  chk_skip_honoured: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_12
    (state_q == SDAS_CONV) |-> !ctrl_q[chan_q])
    else $error("skipped channel converted");
  chk_irq_plain: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_16
    (conv_done_i && state_q == SDAS_CONV && !avg_on) |=> conversion_done_irq_o)
    else $error("conversion interrupt missing");
  chk_one_shot: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_14
    (conv_done_i && state_q == SDAS_CONV && count_q[chan_q] == 8'h00 && !wr_i) |=> !ctrl_q[SDAS_CTRL_START])
    else $error("one-shot did not stop");
  chk_scan_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_18
    scan_end_irq_o |-> $past(conv_done_i) && $past(last_conv) && $past(wrapped))
    else $error("scan end at wrong time");
  chk_count_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_13
    (state_q == SDAS_CONV) |-> (done_cnt_q < chan_total || chan_total == 13'h0000))
    else $error("count overrun");
  cov_scan_end: cover property (@(posedge clk_i) scan_end_irq_o);
  cov_mean: cover property (@(posedge clk_i) mean_done);
  cov_clip: cover property (@(posedge clk_i) res_chan_q[SDAS_CHAN_CLIP]);
  cov_next_turn: cover property (@(posedge clk_i) chan_seen_q && state_q == SDAS_CONV);
  chk_mean_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_17
    (conv_done_i && state_q == SDAS_CONV && avg_on && avg_q[chan_q][SDAS_AVG_MODE_LO] && !mean_done)
    |=> !conversion_done_irq_o) else $error("mean interrupt early");
  chk_single_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // RULE_24
    (scan_end_irq_o && $past(single_mode) && !$past(wr_i)) |-> !ctrl_q[SDAS_CTRL_START])
    else $error("single scan did not stop");
endmodule
`default_nettype wire

/* File: sdas_top_test.sv */
// Self-checking testbench of the sigma-delta autoscan sequencer and result registers.
`default_nettype none
module sdas_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sdas_pkg::*;
  logic        clk_i;                  // System clock, 5 ns period.
  logic        rst_n_i;                // Synchronous reset, active low.
  logic [19:0] addr_i;                 // Register byte address.
  logic        wr_i;                   // Write strobe.
  logic [7:0]  wdata_i;                // Write data.
  logic        rd_i;                   // Read strobe.
  logic        rd16_i;                 // Word read select.
  logic [15:0] rdata_o;                // Registered read data.
  logic        hw_trig_i;              // Hardware trigger mode.
  logic        conv_done_i;            // Filter result pulse.
  logic [23:0] conv_data_i;            // Filter result.
  logic        conv_clip_i;            // Filter result was saturated.
  logic        conv_run_o;             // Sequencer is converting.
  logic [1:0]  conv_chan_o;            // Channel being converted.
  logic [7:0]  conv_param_o;           // Parameters of that channel.
  logic        conversion_done_irq_o;  // Conversion interrupt pulse.
  logic        scan_end_irq_o;         // Scan-end interrupt pulse.
  int          err_count = 0;          // Mismatches seen.
  int          num_checks = 0;         // Comparisons made.
  int          n_cirq = 0;             // Conversion interrupts counted.
  int          n_sirq = 0;             // Scan-end interrupts counted.
  int          base_c;                 // Conversion interrupt count at scenario start.
  int          base_s;                 // Scan-end interrupt count at scenario start.
  int          k;                      // Loop index.
  logic [7:0]  mode;                   // Averaging register value under test.

  sdas_top dut (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .addr_i                (addr_i),
    .wr_i                  (wr_i),
    .wdata_i               (wdata_i),
    .rd_i                  (rd_i),
    .rd16_i                (rd16_i),
    .rdata_o               (rdata_o),
    .hw_trig_i             (hw_trig_i),
    .conv_done_i           (conv_done_i),
    .conv_data_i           (conv_data_i),
    .conv_clip_i           (conv_clip_i),
    .conv_run_o            (conv_run_o),
    .conv_chan_o           (conv_chan_o),
    .conv_param_o          (conv_param_o),
    .conversion_done_irq_o (conversion_done_irq_o),
    .scan_end_irq_o        (scan_end_irq_o)
  );

  // Clock generator.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Counts the one-cycle interrupt pulses so scenarios can compare totals.
  always @(posedge clk_i) begin
    if (conversion_done_irq_o === 1'b1) n_cirq++;
    if (scan_end_irq_o === 1'b1) n_sirq++;
  end

  // Compares a seen value with the expected one and reports a mismatch.
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the totals and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Address of one register inside a channel block.
  function automatic logic [19:0] cha(input int x, input logic [1:0] o);
    return SDAS_ADDR_CH_BASE + SDAS_ADDR_CH_STRIDE * 20'(x) + 20'(o);
  endfunction

  // Byte write; entered and left at a falling edge.
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Byte or word read compared with an expected value; byte reads look at the low byte only.
  task automatic rchk(input string what, input logic [19:0] a, input logic w, input logic [15:0] exp);
    addr_i = a;
    rd16_i = w;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    rd16_i = 1'b0;
    check(what, w ? rdata_o : {8'h00, rdata_o[7:0]}, exp);
    @(negedge clk_i);
  endtask

  // Waits for the sequencer on a channel, delivers one result and checks the stored registers.
  task automatic conv(input logic [1:0] ch, input logic [7:0] prm, input logic [23:0] d, input logic clp);
    int i;
    for (i = 0; i < 50 && conv_run_o !== 1'b1; i++) @(negedge clk_i);
    check("run", conv_run_o, 24'h1);
    check("chan", conv_chan_o, ch);
    check("param", conv_param_o, prm);
    conv_data_i = d;
    conv_clip_i = clp;
    conv_done_i = 1'b1;
    @(negedge clk_i);
    conv_done_i = 0;
    conv_data_i = ~d;
    @(negedge clk_i);
    rchk("res_w0", SDAS_ADDR_RES_CHAN, 1'b1, {d[7:0], 3'(ch) + 3'h1, clp, 4'h0});
    rchk("res_w1", SDAS_ADDR_RES_MID, 1'b1, d[23:8]);
    rchk("res_hi", SDAS_ADDR_RES_HIGH, 1'b0, {8'h00, d[23:16]});
  endtask

  // Waits a few cycles and expects the sequencer to have stopped.
  task automatic stopped(input logic [7:0] ctl);
    repeat (6) @(negedge clk_i);
    check("stopped", conv_run_o, 24'h0);
    rchk("ctrl", SDAS_ADDR_CTRL, 1'b0, {8'h00, ctl});
  endtask

  // Watchdog that ends a hung run.
  initial begin
    #40000;
    err_count++;
    close_out();
  end

  // Main test sequence.
  initial begin
    rst_n_i = 0;
    addr_i = '0;
    wr_i = 0;
    wdata_i = '0;
    rd_i = 0;
    rd16_i = 0;
    hw_trig_i = 0;
    conv_done_i = 0;
    conv_data_i = '0;
    conv_clip_i = 0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    // Reset values, read-only result bytes, unmapped address and idle results.
    check("param_rst", conv_param_o, 24'h40);
    wr(SDAS_ADDR_RES_LOW, 8'hff);
    base_c = n_cirq;
    conv_data_i = 24'h5a5a5a;
    conv_done_i = 1'b1;
    @(negedge clk_i);
    conv_done_i = 0;
    for (k = 0; k < 8; k++) rchk("byte_rst", SDAS_ADDR_RES_CHAN + 20'(k), 1'b0, 16'h0000);
    for (k = 0; k < 8; k += 2) rchk("word_rst", SDAS_ADDR_RES_CHAN + 20'(k), 1'b1, 16'h0000);
    rchk("unmapped", 20'hf0470, 1'b0, 16'h0000);
    check("idle_irq", n_cirq - base_c, 24'h0);
    // Single scan over channels 0, 2, 3 with channel 1 skipped and channel 0 counting twice.
    wr(cha(0, SDAS_CH_OFS_COUNT), 8'h02);
    wr(cha(2, SDAS_CH_OFS_PARAM), 8'h85);
    base_c = n_cirq;
    base_s = n_sirq;
    wr(SDAS_ADDR_CTRL, 8'ha2);
    conv(2'd0, 8'h40, 24'h123456, 1'b0);
    check("mid_scan", n_sirq - base_s, 24'h0);
    conv(2'd0, 8'h40, 24'h7fffff, 1'b1);
    conv(2'd2, 8'h85, 24'h800000, 1'b1);
    conv(2'd3, 8'h40, 24'h00ff01, 1'b0);
    check("conv_irqs", n_cirq - base_c, 24'h4);
    check("scan_irqs", n_sirq - base_s, 24'h1);
    stopped(8'h22);
    // One-shot on channel 2 in continuous mode.
    wr(cha(2, SDAS_CH_OFS_COUNT), 8'h00);
    base_c = n_cirq;
    wr(SDAS_ADDR_CTRL, 8'h8b);
    conv(2'd2, 8'h85, 24'hfedcba, 1'b0);
    check("oneshot_irq", n_cirq - base_c, 24'h1);
    stopped(8'h0b);
    // Continuous scan on channel 1 alone, then stopped by software.
    base_s = n_sirq;
    wr(SDAS_ADDR_CTRL, 8'h8d);
    for (k = 1; k <= 3; k++) conv(2'd1, 8'h40, 24'(k * 24'h010101), 1'b0);
    check("single_ch_scans", n_sirq - base_s, 24'h3);
    wr(SDAS_ADDR_CTRL, 8'h0d);
    stopped(8'h0d);
    // Hardware trigger forces single scanning despite continuous mode.
    hw_trig_i = 1'b1;
    wr(SDAS_ADDR_CTRL, 8'h8d);
    conv(2'd1, 8'h40, 24'h0a0b0c, 1'b0);
    stopped(8'h0d);
    hw_trig_i = 0;
    // Averaging of eight results on channel 0, interrupt per conversion then per mean.
    wr(cha(0, SDAS_CH_OFS_COUNT), 8'h08);
    for (k = 0; k < 2; k++) begin
      mode = (k == 0) ? 8'h08 : 8'h0c;
      wr(cha(0, SDAS_CH_OFS_AVG), mode);
      base_c = n_cirq;
      wr(SDAS_ADDR_CTRL, 8'hae);
      for (int j = 1; j <= 8; j++) conv(2'd0, 8'h40, 24'(j * 16), j == 3);
      repeat (4) @(negedge clk_i);
      check("avg_irqs", n_cirq - base_c, (k == 0) ? 24'h8 : 24'h1);
      rchk("mean_w0", SDAS_ADDR_MEAN_CHAN, 1'b1, 16'h4830);
      rchk("mean_w1", SDAS_ADDR_MEAN_MID, 1'b1, 16'h0000);
      rchk("mean_lo", SDAS_ADDR_MEAN_LOW, 1'b0, 16'h0048);
      rchk("mean_ch", SDAS_ADDR_MEAN_CHAN, 1'b0, 16'h0030);
      stopped(8'h2e);
    end
    // Linear count 21h: 33 conversions.
    wr(cha(1, SDAS_CH_OFS_AVG), 8'h80);
    wr(cha(1, SDAS_CH_OFS_COUNT), 8'h21);
    base_s = n_sirq;
    wr(SDAS_ADDR_CTRL, 8'had);
    for (k = 0; k < 33; k++) conv(2'd1, 8'h40, 24'(k), 1'b0);
    check("lin_scans", n_sirq - base_s, 24'h1);
    stopped(8'h2d);
    close_out();
  end
endmodule
`default_nettype wire
